//--- design/sramc_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - access only with both enables low
// - strobe low writes, high reads
// - hold output_disable high during writes
// - data taken at strobe rising edge
// - enables low long enough before strobe rises
// - enables held high through standby
// - wait recovery time after standby
module sramc_host #(
  parameter int ADDR_W = sramc_pkg::ADDR_W,
  parameter int DATA_W = sramc_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic standby_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic in_standby,
  output logic chip_enable_a_n,
  output logic chip_enable_b_n,
  output logic write_strobe_n,
  output logic output_disable,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_in
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sramc_pkg::sramc_state_e fsm;
    logic [sramc_pkg::CNT_W-1:0] cnt;
    logic [sramc_pkg::CNT_W-1:0] gap;
    logic was_write;
    logic ready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic stby;
    sramc_pkg::sramc_pins_s pins;
  } sramc_host_s;

  sramc_host_s st;
  sramc_host_s next_st;

  function automatic logic [sramc_pkg::CNT_W-1:0] cyc(input int n);
    cyc = sramc_pkg::CNT_W'(n - 1);
  endfunction

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    case (st.fsm)
      sramc_pkg::SRAMC_IDLE: begin
        next_st.pins.chip_enable_a_n = 1'b1;
        next_st.pins.chip_enable_b_n = 1'b1;
        next_st.pins.write_strobe_n = 1'b1;
        next_st.pins.output_disable = 1'b1;
        next_st.pins.dq_oe = 1'b0;
        if (standby_req) begin
          // enables already high here, so the device floats before power drops
          next_st.fsm = sramc_pkg::SRAMC_STBY;
          next_st.stby = 1'b1;
          next_st.ready = 1'b0;
        end else if (req_valid && st.ready) begin
          next_st.ready = 1'b0;
          next_st.pins.addr = req_addr;
          next_st.pins.chip_enable_a_n = 1'b0;
          next_st.pins.chip_enable_b_n = 1'b0;
          next_st.was_write = req_write;
          if (req_write) begin
            next_st.pins.write_strobe_n = 1'b0;
            next_st.pins.output_disable = 1'b1;
            next_st.pins.dq_out = req_wdata;
            next_st.pins.dq_oe = 1'b1;
            next_st.cnt = cyc(sramc_pkg::CW_CYC);
            next_st.fsm = sramc_pkg::SRAMC_WR;
          end else begin
            next_st.pins.output_disable = 1'b0;
            next_st.cnt = cyc(sramc_pkg::RC_CYC);
            next_st.fsm = sramc_pkg::SRAMC_RD;
          end
        end
      end
      sramc_pkg::SRAMC_RD: begin
        // full read cycle covers access time from address and enable
        if (st.cnt == '0) begin
          next_st.rdata = dq_in;
          next_st.rvalid = 1'b1;
          next_st.pins.chip_enable_a_n = 1'b1;
          next_st.pins.chip_enable_b_n = 1'b1;
          next_st.pins.output_disable = 1'b1;
          next_st.gap = cyc(sramc_pkg::DF_CYC);
          next_st.fsm = sramc_pkg::SRAMC_GAP;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      sramc_pkg::SRAMC_WR: begin
        // strobe low covers pulse width, enable setup and data setup
        if (st.cnt == '0) begin
          next_st.pins.write_strobe_n = 1'b1;
          next_st.cnt = cyc(sramc_pkg::DH_CYC);
          next_st.fsm = sramc_pkg::SRAMC_WHOLD;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      sramc_pkg::SRAMC_WHOLD: begin
        // data and address stay past the rising edge for hold time
        if (st.cnt == '0) begin
          next_st.pins.dq_oe = 1'b0;
          next_st.pins.chip_enable_a_n = 1'b1;
          next_st.pins.chip_enable_b_n = 1'b1;
          next_st.gap = cyc(sramc_pkg::DF_CYC);
          next_st.fsm = sramc_pkg::SRAMC_GAP;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      sramc_pkg::SRAMC_GAP: begin
        // lets the device release the bus before the next owner drives it
        if (st.gap == '0) begin
          next_st.ready = 1'b1;
          next_st.fsm = sramc_pkg::SRAMC_IDLE;
        end else begin
          next_st.gap = st.gap - 1'b1;
        end
      end
      sramc_pkg::SRAMC_STBY: begin
        if (st.stby) begin
          if (!standby_req) begin
            next_st.stby = 1'b0;
            next_st.gap = cyc(sramc_pkg::REC_CYC);
          end
        end else if (st.gap == '0) begin
          next_st.ready = 1'b1;
          next_st.fsm = sramc_pkg::SRAMC_IDLE;
        end else begin
          next_st.gap = st.gap - 1'b1;
        end
      end
      default: begin
        next_st.fsm = sramc_pkg::SRAMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
      st.fsm <= sramc_pkg::SRAMC_IDLE;
      st.ready <= 1'b1;
      st.pins.chip_enable_a_n <= 1'b1;
      st.pins.chip_enable_b_n <= 1'b1;
      st.pins.write_strobe_n <= 1'b1;
      st.pins.output_disable <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign req_ready = st.ready;
  assign rsp_valid = st.rvalid;
  assign rsp_rdata = st.rdata;
  assign in_standby = (st.fsm == sramc_pkg::SRAMC_STBY);
  assign chip_enable_a_n = st.pins.chip_enable_a_n;
  assign chip_enable_b_n = st.pins.chip_enable_b_n;
  assign write_strobe_n = st.pins.write_strobe_n;
  assign output_disable = st.pins.output_disable;
  assign mem_addr = st.pins.addr;
  assign dq_out = st.pins.dq_out;
  assign dq_oe = st.pins.dq_oe;

  // ****************************************************************
  // assertions
  // ****************************************************************
  int unsigned low_run;
  always_ff @(posedge mclk) begin
    if (reset || chip_enable_a_n || write_strobe_n) begin
      low_run <= 0;
    end else begin
      low_run <= low_run + 1;
    end
  end

  property p_strobe_needs_enable;
    @(posedge mclk) disable iff (reset) !write_strobe_n |-> (!chip_enable_a_n && !chip_enable_b_n);
  endproperty
  a_strobe_needs_enable: assert property (p_strobe_needs_enable) else $error("strobe low while deselected");

  property p_od_during_write;
    @(posedge mclk) disable iff (reset) (!write_strobe_n || dq_oe) |-> output_disable;
  endproperty
  a_od_during_write: assert property (p_od_during_write) else $error("output enabled while writing");

  property p_no_contention;
    @(posedge mclk) disable iff (reset) dq_oe |-> (output_disable || chip_enable_a_n || !write_strobe_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("both ends may drive the bus");

  property p_enable_setup;
    @(posedge mclk) disable iff (reset) ($rose(write_strobe_n)) |-> ($past(low_run) >= sramc_pkg::CW_CYC - 1);
  endproperty
  a_enable_setup: assert property (p_enable_setup) else $error("strobe too short");

  property p_data_hold;
    @(posedge mclk) disable iff (reset) $rose(write_strobe_n) |-> dq_oe && $stable(dq_out) && $stable(mem_addr);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at strobe edge");

  property p_standby_deselect;
    @(posedge mclk) disable iff (reset) in_standby |-> (chip_enable_a_n && chip_enable_b_n && !dq_oe);
  endproperty
  a_standby_deselect: assert property (p_standby_deselect) else $error("enabled in standby");

  property p_recovery;
    @(posedge mclk) disable iff (reset) $fell(st.stby) |-> !req_ready [*8];
  endproperty
  a_recovery: assert property (p_recovery) else $error("ready too soon after standby");

  property p_read_mode;
    @(posedge mclk) disable iff (reset) (st.fsm == sramc_pkg::SRAMC_RD) |-> write_strobe_n && !output_disable;
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("read without strobe high");

  property p_float_gap;
    @(posedge mclk) disable iff (reset) $fell(dq_oe) |-> !req_ready [*8];
  endproperty
  a_float_gap: assert property (p_float_gap) else $error("bus turnaround too short");

  c_write: cover property (@(posedge mclk) $rose(write_strobe_n));
  c_read: cover property (@(posedge mclk) rsp_valid);
  c_standby: cover property (@(posedge mclk) $fell(in_standby));
endmodule // sramc_host

//--- design/sramc_pkg.sv
package sramc_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int WORDS = 256;
  // ****************************************************************
  // timing, ns and derived cycle counts at 10 ns per mclk
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RC_NS = 1000;
  localparam int T_WP_NS = 750;
  localparam int T_CW_NS = 900;
  localparam int T_DW_NS = 700;
  localparam int T_DH_NS = 100;
  localparam int T_DF_NS = 200;
  localparam int T_REC_NS = T_RC_NS;
  localparam int RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CW_CYC = (T_CW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DW_CYC = (T_DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DH_CYC = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DF_CYC = (T_DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [5:0] {
    SRAMC_IDLE = 6'h01,
    SRAMC_RD = 6'h02,
    SRAMC_WR = 6'h04,
    SRAMC_WHOLD = 6'h08,
    SRAMC_GAP = 6'h10,
    SRAMC_STBY = 6'h20
  } sramc_state_e;
  typedef struct packed {
    logic chip_enable_a_n;
    logic chip_enable_b_n;
    logic write_strobe_n;
    logic output_disable;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } sramc_pins_s;
endpackage

//--- dv/sramc_dev_model.sv
`timescale 1ns/1ps
// ****************************************************************
// device model: 256 x 4 static store with shared data pins
// ****************************************************************
module sramc_dev_model #(
  parameter int ACC_NS = 500
) (
  input wire logic chip_enable_a_n,
  input wire logic chip_enable_b_n,
  input wire logic write_strobe_n,
  input wire logic output_disable,
  input wire logic [7:0] mem_addr,
  input wire logic [3:0] dq_bus,
  output logic [3:0] dev_q,
  output logic dev_oe
);
  logic [3:0] cells [256];
  logic sel;
  assign sel = !chip_enable_a_n && !chip_enable_b_n;
  assign dev_oe = sel && !output_disable && write_strobe_n;
  // slow part: the word shows only after the access delay
  assign #(ACC_NS) dev_q = cells[mem_addr];
  // cells change only on a completed write, so standby keeps them
  always @(posedge write_strobe_n) begin
    if (sel) cells[mem_addr] <= dq_bus;
  end
endmodule // sramc_dev_model

//--- dv/sramc_host_tb.sv
`timescale 1ns/1ps
module sramc_host_tb;
  // ****************************************************************
  // clock, pins and bus resolution
  // ****************************************************************
  logic mclk, reset, req_valid, req_write, standby_req;
  logic [7:0] req_addr, mem_addr;
  logic [3:0] req_wdata, rsp_rdata, dq_out, dq_in, dev_q;
  logic [3:0] dq_last = 4'h5;
  logic req_ready, rsp_valid, in_standby, dq_oe, dev_oe;
  logic chip_enable_a_n, chip_enable_b_n, write_strobe_n, output_disable;
  int num_errors = 0;
  int compares = 0;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // no pull on the data lines: a floating bus shows the inverse of its last value
  assign dq_in = dq_oe ? dq_out : (dev_oe ? dev_q : ~dq_last);
  always @(posedge mclk) if (dq_oe || dev_oe) dq_last <= dq_in;
  sramc_host dut_u (.mclk(mclk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .standby_req(standby_req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .in_standby(in_standby),
    .chip_enable_a_n(chip_enable_a_n), .chip_enable_b_n(chip_enable_b_n),
    .write_strobe_n(write_strobe_n), .output_disable(output_disable), .mem_addr(mem_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  sramc_dev_model #(.ACC_NS(900)) dev_u (.chip_enable_a_n(chip_enable_a_n),
    .chip_enable_b_n(chip_enable_b_n), .write_strobe_n(write_strobe_n),
    .output_disable(output_disable), .mem_addr(mem_addr), .dq_bus(dq_in), .dev_q(dev_q),
    .dev_oe(dev_oe));
  // ****************************************************************
  // checking helpers and tasks
  // ****************************************************************
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_req(input logic wr, input logic [7:0] a, input logic [3:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(4'(n < 500), 4'h1);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
  endtask
  task automatic read_chk(input logic [7:0] a, input logic [3:0] exp);
    int n;
    n = 0;
    do_req(1'b0, a, 4'h0);
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(4'(n < 300), 4'h1);
    chk(rsp_rdata, exp);
  endtask
  // wire rules watched mid-cycle, where the registered pins have settled
  always @(negedge mclk) begin
    if (reset === 1'b0) begin
      if (!write_strobe_n && (chip_enable_a_n || chip_enable_b_n)) chk(4'h1, 4'h0);
      if (!write_strobe_n && !output_disable) chk(4'h2, 4'h0);
      if (dq_oe && dev_oe) chk(4'h3, 4'h0);
      if (in_standby && !(chip_enable_a_n && chip_enable_b_n)) chk(4'h4, 4'h0);
    end
  end
  initial begin
    #600000;
    num_errors++;
    test_done;
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_rw_corners;
    logic [7:0] at [4];
    logic [3:0] dt [4];
    at = '{8'h00, 8'hFF, 8'h01, 8'h80};
    dt = '{4'hA, 4'h5, 4'hF, 4'h0};
    for (int i = 0; i < 4; i++) do_req(1'b1, at[i], dt[i]);
    for (int i = 0; i < 4; i++) read_chk(at[i], dt[i]);
    do_req(1'b1, 8'h01, 4'h6);
    read_chk(8'h01, 4'h6);
    read_chk(8'h00, 4'hA);
  endtask
  task automatic t_standby;
    int n;
    standby_req = 1'b1;
    repeat (40) @(posedge mclk);
    #1;
    chk({3'h0, in_standby}, 4'h1);
    chk({2'h0, chip_enable_a_n, chip_enable_b_n}, 4'h3);
    standby_req = 1'b0;
    n = 0;
    while (chip_enable_a_n !== 1'b0 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
      if (n == 2) begin
        req_valid = 1'b1;
        req_write = 1'b0;
        req_addr = 8'hFF;
      end
      if (req_ready === 1'b1) req_valid = 1'b1;
    end
    req_valid = 1'b0;
    chk(4'(n >= sramc_pkg::REC_CYC), 4'h1);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(4'(n < 300), 4'h1);
    chk(rsp_rdata, 4'h5);
  endtask
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_wdata = 4'h0;
    standby_req = 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    reset = 1'b0;
    chk({chip_enable_a_n, chip_enable_b_n, output_disable, dq_oe}, 4'hE);
    chk({write_strobe_n, req_ready, rsp_valid, 1'b0}, 4'hC);
    t_rw_corners;
    t_standby;
    read_chk(8'h80, 4'h0);
    test_done;
  end
endmodule // sramc_host_tb
